// *** tpp_defines.svh ***
`ifndef TPP_DEFINES_SVH
`define TPP_DEFINES_SVH
`define TPP_NUM_PORTS 64
`define TPP_NUM_GROUPS 8
`define TPP_NUM_WORDS 2
`define TPP_OFS_ENABLE0 12'h000
`define TPP_OFS_ENABLE1 12'h004
`define TPP_PORTS_PER_GROUP 8
`define TPP_CTRL_RSVD_MASK 32'hFF00F000
`define TPP_OFS_PRIV_MASK 12'h040
`define TPP_OFS_CONTROL 12'h080
`define TPP_BUSY_BIT 23
`define TPP_ID_HI 22
`define TPP_ID_LO 16
`define TPP_ID_RESET 7'h00
`define TPP_MASK_RESET 32'h00000000
`define TPP_ENABLE_RESET 32'h00000000
`endif

// *** tpp_pkg.sv ***
package tpp_pkg;
  typedef logic [6:0] tpp_id_t;
  typedef logic [31:0] tpp_word_t;
endpackage

// *** tpp_drain_monitor.sv ***
`timescale 1ns/1ps
module tpp_drain_monitor
  import tpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic events_pending,
  output logic busy
);
  logic sync1_r;
  logic sync2_r;

  // two-stage synchroniser for the pending level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= events_pending;
      sync2_r <= sync1_r;
    end
  end

  assign busy = sync2_r;
endmodule

// *** tpp_trace_port_privilege_control.sv ***
// Overview of operation
// - each mask bit covers eight ports
// - ports implemented in gapless multiples of eight
// - unimplemented mask bits read zero, ignore writes
// - mask bit one means privileged access only
// - unprivileged enable writes blocked by set mask
// - busy flag at control bit 23, read-only
// - seven-bit source identifier at bits 22:16
`timescale 1ns/1ps
`include "tpp_defines.svh"
module tpp_trace_port_privilege_control
  import tpp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic events_pending,
  input wire logic [7:0] port_access_req,
  input wire logic port_access_priv,
  output logic [7:0] port_access_ok,
  output logic [`TPP_NUM_PORTS-1:0] port_enable,
  output logic [6:0] trace_source_identifier
);
  localparam int NG = `TPP_NUM_GROUPS;
  localparam int NW = `TPP_NUM_WORDS;
  localparam int NP = `TPP_NUM_PORTS;
  localparam int NB = 32;
  localparam int NSEL = 4;
  localparam int SEL_MASK = 2;
  localparam int SEL_CTRL = 3;

  tpp_word_t port_group_priv_bits_r;
  tpp_word_t port_enable_words_r [NW];
  tpp_id_t trace_source_identifier_r;
  tpp_word_t prdata_r;
  tpp_word_t rdata_nxt;
  tpp_word_t ctrl_rdata;
  logic busy;
  logic wr_en;
  logic rd_en;
  logic priv_acc;
  logic mask_wr;
  logic id_wr;
  logic [NSEL-1:0] wr_sel;
  logic [NSEL-1:0] rd_sel;
  logic [31:0] wmask;
  logic [NG-1:0] group_locked;
  logic [NG-1:0] group_open;
  logic [NP-1:0] port_locked;
  logic [NP-1:0] enable_rdata;

  // byte-lane write mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // lane-masked merge of write data into a word
  function automatic logic [31:0] merge_word(input logic [31:0] old_v, input logic [31:0] new_v, input logic [31:0] m);
    merge_word = (old_v & ~m) | (new_v & m);
  endfunction

  // mask of implemented privilege bits
  function automatic logic [31:0] impl_groups();
    impl_groups = 32'h0;
    for (int g = 0; g < NG; g++) begin
      impl_groups[g] = 1'b1;
    end
  endfunction

  // mask of implemented ports within one enable word
  function automatic logic [31:0] impl_ports(input int word);
    impl_ports = 32'h0;
    for (int b = 0; b < NB; b++) begin
      if (word * NB + b < NP) begin
        impl_ports[b] = 1'b1;
      end
    end
  endfunction

  // group that a stimulus port belongs to
  function automatic int port_group(input int port);
    port_group = port / `TPP_PORTS_PER_GROUP;
  endfunction

  // one-hot register select from a byte address
  function automatic logic [NSEL-1:0] reg_sel(input logic [11:0] a);
    reg_sel = 4'h0;
    if (a == `TPP_OFS_ENABLE0) begin
      reg_sel = 4'h1;
    end else if (a == `TPP_OFS_ENABLE1) begin
      reg_sel = 4'h2;
    end else if (a == `TPP_OFS_PRIV_MASK) begin
      reg_sel = 4'h4;
    end else if (a == `TPP_OFS_CONTROL) begin
      reg_sel = 4'h8;
    end
  endfunction

  // synchronised pending level becomes the busy flag
  tpp_drain_monitor u_drain (
    .pclk(pclk),
    .presetn(presetn),
    .events_pending(events_pending),
    .busy(busy)
  );

  // zero-wait slave: writes land in the access cycle, reads sample in setup
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign wr_sel = wr_en ? reg_sel(paddr) : 4'h0;
  assign rd_sel = rd_en ? reg_sel(paddr) : 4'h0;
  assign priv_acc = pprot[0];
  assign wmask = lane_mask(pstrb);
  assign mask_wr = wr_sel[SEL_MASK] && priv_acc;
  assign id_wr = wr_sel[SEL_CTRL] && priv_acc && pstrb[2];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // privilege mask: privileged writes only, unimplemented groups kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_group_priv_bits_r <= `TPP_MASK_RESET;
    end else if (mask_wr) begin
      port_group_priv_bits_r <= merge_word(port_group_priv_bits_r, pwdata, wmask) & impl_groups();
    end
  end

  // source identifier: privileged writes with its byte lane enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_source_identifier_r <= `TPP_ID_RESET;
    end else if (id_wr) begin
      trace_source_identifier_r <= pwdata[`TPP_ID_HI:`TPP_ID_LO];
    end
  end

  // per-group lock and grant
  genvar w;
  genvar p;
  generate
    for (w = 0; w < NG; w++) begin : g_acc
      // group w spans ports 8w..8w+7
      assign group_locked[w] = port_group_priv_bits_r[w];
      assign group_open[w] = port_access_priv || !group_locked[w];
      assign port_access_ok[w] = port_access_req[w] && group_open[w];
    end
  endgenerate

  // each port inherits the lock of its group of eight
  generate
    for (p = 0; p < NP; p++) begin : g_lock
      assign port_locked[p] = group_locked[port_group(p)];
    end
  endgenerate

  // enable words: unprivileged writes skip bits of locked groups
  generate
    for (w = 0; w < NW; w++) begin : g_en
      logic [31:0] allow;
      always_comb begin
        allow = wmask & impl_ports(w);
        if (!priv_acc) begin
          allow = allow & ~port_locked[w*32 +: 32];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          port_enable_words_r[w] <= `TPP_ENABLE_RESET;
        end else if (wr_sel[w]) begin
          port_enable_words_r[w] <= merge_word(port_enable_words_r[w], pwdata, allow);
        end
      end
      assign port_enable[w*32 +: 32] = port_enable_words_r[w];
      assign enable_rdata[w*32 +: 32] = port_enable_words_r[w] & impl_ports(w);
    end
  endgenerate

  // control word: busy and identifier, reserved fields read zero
  always_comb begin
    ctrl_rdata = 32'h0;
    ctrl_rdata[`TPP_BUSY_BIT] = busy;
    ctrl_rdata[`TPP_ID_HI:`TPP_ID_LO] = trace_source_identifier_r;
    ctrl_rdata = ctrl_rdata & ~`TPP_CTRL_RSVD_MASK;
  end

  // read data chosen in the setup cycle, unmapped reads give zero
  always_comb begin
    rdata_nxt = 32'h0;
    if (rd_sel[0]) begin
      rdata_nxt = enable_rdata[31:0];
    end else if (rd_sel[1]) begin
      rdata_nxt = enable_rdata[63:32];
    end else if (rd_sel[SEL_MASK]) begin
      rdata_nxt = port_group_priv_bits_r & impl_groups();
    end else if (rd_sel[SEL_CTRL]) begin
      rdata_nxt = ctrl_rdata;
    end
  end

  // read data held from the setup cycle through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (rd_en) begin
      prdata_r <= rdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign trace_source_identifier = trace_source_identifier_r;
endmodule

// *** tpp_chk_sva.sv ***
`timescale 1ns/1ps
module tpp_chk
  import tpp_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic events_pending,
  input logic port_access_priv,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [3:0] pstrb,
  input logic [2:0] pprot,
  input logic [7:0] port_access_req,
  input logic [7:0] port_access_ok,
  input logic [63:0] port_enable,
  input logic [6:0] trace_source_identifier
);
  logic [7:0] m_r;
  logic [31:0] e;
  wire acc = psel && penable;
  wire wc = acc && pwrite && paddr == 12'h080;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) m_r <= 8'h00;
    else if (acc && pwrite && paddr == 12'h040 && pprot[0] && pstrb[0]) m_r <= pwdata[7:0];
  always_comb for (int i = 0; i < 32; i++) e[i] = m_r[i/8];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rc; acc && !pwrite && paddr == 12'h080; endsequence
  property p_gr; port_access_ok == (port_access_req & (port_access_priv ? 8'hFF : ~m_r)); endproperty
  property p_en; acc && pwrite && paddr == 12'h000 && !pprot[0] |=>
    (port_enable[31:0] & e) == ($past(port_enable[31:0]) & e); endproperty
  property p_b1; events_pending [*5] ##0 s_rc |-> prdata[23]; endproperty
  property p_b0; (!events_pending) [*5] ##0 s_rc |-> !prdata[23]; endproperty
  property p_iw; wc && pprot[0] && pstrb[2] |=> trace_source_identifier == $past(pwdata[22:16]); endproperty
  property p_iu; wc && !pprot[0] |=> $stable(trace_source_identifier); endproperty
  property p_rs; s_rc |-> prdata[31:24] == 8'h00 && prdata[15:12] == 4'h0; endproperty
  property p_rz; acc && !pwrite && paddr == 12'h040 |-> prdata[31:8] == 24'h000000; endproperty
  property p_rd; acc |-> pready && !pslverr; endproperty
  a_gr: assert property (p_gr) else $error("grant");
  a_en: assert property (p_en) else $error("enable");
  a_b1: assert property (p_b1) else $error("busy1");
  a_b0: assert property (p_b0) else $error("busy0");
  a_iw: assert property (p_iw) else $error("id");
  a_iu: assert property (p_iu) else $error("idu");
  a_rs: assert property (p_rs) else $error("resv");
  a_rz: assert property (p_rz) else $error("raz");
  a_rd: assert property (p_rd) else $error("ready");
endmodule
bind tpp_trace_port_privilege_control tpp_chk i_chk (.*);

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(a,b) begin checks++; if ((a)!==(b)) begin failures++; $display("[FAIL] %0t %h %h",$time,a,b); end end
module tb
  import tpp_pkg::*;
;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [2:0] p; logic [31:0] e;} tpp_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, events_pending = 0, port_access_priv = 0;
  logic pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [2:0] pprot = 0;
  logic [7:0] port_access_req = 0, port_access_ok;
  logic [63:0] port_enable;
  logic [6:0] trace_source_identifier;
  int checks = 0, failures = 0;
  tpp_row_t rows [11] = '{'{1, 12'h040, 32'hFFFFFFFF, 1, 0}, '{0, 12'h040, 0, 1, 32'hFF},
    '{1, 12'h000, 32'hFFFFFFFF, 0, 0}, '{0, 12'h000, 0, 0, 0}, '{1, 12'h040, 32'h0F, 1, 0},
    '{1, 12'h004, 32'hFFFFFFFF, 0, 0}, '{0, 12'h004, 0, 0, 32'hFFFFFFFF}, '{1, 12'h080, 32'hFFFFFFFF, 1, 0},
    '{1, 12'h080, 0, 0, 0}, '{0, 12'h080, 0, 0, 32'h007F0000}, '{0, 12'h100, 0, 0, 0}};
  tpp_trace_port_privilege_control i_dut (.pstrb(4'hF), .*);
  initial forever #5 pclk = ~pclk;
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] p);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pprot} <= {2'h2, w, a, d, p};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1);
    r = prdata;
    {psel, penable} <= 2'h0;
  endtask
  task print_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].p);
      if (!rows[i].w) `CHK(r, rows[i].e)
    end
    `CHK(trace_source_identifier, 7'h7F)
    `CHK(port_enable, 64'hFFFFFFFF00000000)
    events_pending <= 1;
    repeat (5) @(posedge pclk);
    apb(0, 12'h080, 0, 0);
    `CHK(r, 32'h00FF0000)
    {events_pending, port_access_req} <= {1'h0, 8'hFF};
    @(posedge pclk);
    `CHK(port_access_ok, 8'hF0)
    port_access_priv <= 1;
    @(posedge pclk);
    `CHK(port_access_ok, 8'hFF)
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h040, 0, 1);
    `CHK({r, port_enable}, 96'h0)
    print_verdict;
  end
endmodule
